//--- src/tag_ac_cfg.svh
// constants for the tag anticollision state logic
`ifndef TAG_AC_CFG_SVH
`define TAG_AC_CFG_SVH
`define AC_ID_W 8
`define AC_SLOT_W 4
`define AC_SLOT_LSB 0
`define AC_LFSR_SEED 16'hACE1
`define AC_LFSR_TAPS 16'hB400
`define AC_ID_RESET 8'h00
`endif

//--- src/tag_ac_pkg.sv
// types for the tag anticollision state logic
package tag_ac_pkg;
  typedef enum logic [2:0] {
    ST_READY = 3'h0,
    ST_INVENTORY = 3'h1,
    ST_SELECTED = 3'h3,
    ST_DESELECTED = 3'h2,
    ST_DEACTIVATED = 3'h6
  } tag_state_e;
  typedef enum logic [2:0] {
    CMD_INITIATE = 3'h0,
    CMD_POLL = 3'h1,
    CMD_PROBE = 3'h2,
    CMD_SELECT = 3'h3,
    CMD_COMPLETION = 3'h4,
    CMD_RESET_INV = 3'h5
  } tag_cmd_e;
endpackage

//--- src/tag_random_gen.sv
// free-running galois lfsr used as the tag's random source
`timescale 1ns/1ps
`include "tag_ac_cfg.svh"
module tag_random_gen #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic [WIDTH-1:0] rnd
);
  logic [WIDTH-1:0] lfsr_r;
  logic [WIDTH-1:0] lfsr_nxt;

  // the tap mask is laid out for a sixteen-bit register only
  generate
    if (WIDTH != 16) begin : g_bad_width
      $error("tag_random_gen: WIDTH must be 16");
    end
  endgenerate

  // runs every cycle so the value drawn depends on command arrival time
  always_comb begin
    lfsr_nxt = lfsr_r >> 1;
    if (lfsr_r[0]) begin
      lfsr_nxt = lfsr_nxt ^ `AC_LFSR_TAPS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lfsr_r <= `AC_LFSR_SEED;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  assign rnd = lfsr_r;
endmodule

//--- src/tag_anticollision_sequence.sv
// tag-side anticollision state machine and identifier answer logic
//
// Functional notes
// R01: start-inventory moves ready tags into inventory
// R02: poll and probe answered only in inventory
// R03: tag in ready ignores poll and probe
// R04: start-inventory draws new identifier and answers
// R05: each poll draws fresh random slot value
// R06: reader repeats start-inventory on silence
// R07: reader selects single answer, else polls
// R08: reader stores single slot-zero answer, selects
// R09: reader probes slots one through fifteen
// R10: reader keeps every decoded identifier
// R11: reader accesses stored tags one by one
// R12: reader restarts at poll after collisions
// R13: reader may stop once all identified
// R14: slot value is identifier low nibble
// R15: probe answered only when slot matches
// R16: selected tag ignores anticollision commands
// R17: reader counts undecodable energy as collision
`timescale 1ns/1ps
`include "tag_ac_cfg.svh"
module tag_anticollision_sequence #(
  parameter int ID_W = `AC_ID_W,
  parameter int SLOT_W = `AC_SLOT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] probe_slot_number,
  input wire logic [7:0] cmd_select_id,
  output logic resp_valid,
  output logic [7:0] resp_id,
  output logic [7:0] session_identifier,
  output logic [2:0] tag_state,
  output logic tag_selected
);
  // ************************************************************
  // random source
  // ************************************************************
  logic [15:0] rnd;

  tag_random_gen #(.WIDTH(16)) u_rnd (
    .sys_clk(sys_clk),
    .reset(reset),
    .rnd(rnd)
  );

  // ************************************************************
  // parameter checks
  // ************************************************************
  // ports and the slot field are laid out for these sizes only
  generate
    if (ID_W != `AC_ID_W || SLOT_W != `AC_SLOT_W) begin : g_bad_size
      $error("tag_anticollision_sequence: unsupported ID_W or SLOT_W");
    end
  endgenerate

  // ************************************************************
  // state and identifier
  // ************************************************************
  tag_ac_pkg::tag_state_e state_r;
  tag_ac_pkg::tag_state_e state_nxt;
  logic [7:0] id_r;
  logic [7:0] id_nxt;
  logic resp_valid_r;
  logic resp_valid_nxt;
  logic [7:0] resp_id_r;
  logic [7:0] resp_id_nxt;
  logic id_seeded_r;
  logic id_seeded_nxt;
  logic [3:0] new_slot;

  assign new_slot = rnd[`AC_SLOT_LSB +: `AC_SLOT_W];

  // ************************************************************
  // command decode
  // ************************************************************
  // one strobe per command keeps the state case below readable
  logic do_initiate;
  logic do_poll;
  logic do_probe;
  logic do_select;
  logic do_completion;
  logic do_reset_inv;
  logic id_match;
  logic probe_hit;
  logic [SLOT_W-1:0] cur_slot;

  always_comb begin
    do_initiate = 1'b0;
    do_poll = 1'b0;
    do_probe = 1'b0;
    do_select = 1'b0;
    do_completion = 1'b0;
    do_reset_inv = 1'b0;
    if (cmd_valid) begin
      case (cmd_code)
        tag_ac_pkg::CMD_INITIATE: do_initiate = 1'b1;
        tag_ac_pkg::CMD_POLL: do_poll = 1'b1;
        tag_ac_pkg::CMD_PROBE: do_probe = 1'b1;
        tag_ac_pkg::CMD_SELECT: do_select = 1'b1;
        tag_ac_pkg::CMD_COMPLETION: do_completion = 1'b1;
        tag_ac_pkg::CMD_RESET_INV: do_reset_inv = 1'b1;
        default: begin
          // unused codes are dropped like a frame that failed decoding
        end
      endcase
    end
  end

  assign id_match = (cmd_select_id == id_r);
  assign cur_slot = id_r[`AC_SLOT_LSB +: SLOT_W]; // R14
  // slot zero belongs to the poll, so a zero probe is dropped
  assign probe_hit = (probe_slot_number != 4'h0) &&
    (probe_slot_number == cur_slot); // R15

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    id_nxt = id_r;
    resp_valid_nxt = 1'b0;
    resp_id_nxt = resp_id_r;
    id_seeded_nxt = 1'b1;
    // identifier starts random on entering the field
    if (!id_seeded_r) begin
      id_nxt = rnd[15:8];
    end
    case (state_r)
      tag_ac_pkg::ST_READY: begin
        // poll and probe fall through unanswered here
        if (do_initiate) begin // R03
          state_nxt = tag_ac_pkg::ST_INVENTORY; // R01
          id_nxt = rnd[7:0]; // R04
          resp_valid_nxt = 1'b1; // R04
          resp_id_nxt = rnd[7:0];
        end
      end
      tag_ac_pkg::ST_INVENTORY: begin
        if (do_initiate) begin
          id_nxt = rnd[7:0]; // R04
          resp_valid_nxt = 1'b1;
          resp_id_nxt = rnd[7:0];
        end else if (do_poll) begin // R02
          // only the slot nibble is redrawn; the high nibble stays
          id_nxt = {id_r[7:4], new_slot}; // R05 R14
          if (new_slot == 4'h0) begin
            resp_valid_nxt = 1'b1;
            resp_id_nxt = {id_r[7:4], new_slot};
          end
        end else if (do_probe) begin // R02
          if (probe_hit) begin // R15
            resp_valid_nxt = 1'b1;
            resp_id_nxt = id_r;
          end
        end else if (do_select && id_match) begin
          state_nxt = tag_ac_pkg::ST_SELECTED;
          resp_valid_nxt = 1'b1;
          resp_id_nxt = id_r;
        end
      end
      tag_ac_pkg::ST_SELECTED: begin
        // anticollision commands get no answer here
        if (do_select) begin // R16
          // a repeated matching select answers again and stays put
          if (id_match) begin
            resp_valid_nxt = 1'b1;
            resp_id_nxt = id_r;
          end else begin
            state_nxt = tag_ac_pkg::ST_DESELECTED;
          end
        end else if (do_completion) begin
          state_nxt = tag_ac_pkg::ST_DEACTIVATED;
        end else if (do_reset_inv) begin
          // identifier is kept; the next poll redraws its slot
          state_nxt = tag_ac_pkg::ST_INVENTORY;
        end
      end
      tag_ac_pkg::ST_DESELECTED: begin
        if (do_select && id_match) begin
          state_nxt = tag_ac_pkg::ST_SELECTED;
          resp_valid_nxt = 1'b1;
          resp_id_nxt = id_r;
        end
      end
      default: begin
        // deactivated: only leaving the field (reset) frees it
        state_nxt = state_r;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= tag_ac_pkg::ST_READY;
      id_r <= `AC_ID_RESET;
      resp_valid_r <= 1'b0;
      resp_id_r <= `AC_ID_RESET;
      id_seeded_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      id_r <= id_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_id_r <= resp_id_nxt;
      id_seeded_r <= id_seeded_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // straight from flops so an answer stands for one whole cycle
  assign resp_valid = resp_valid_r;
  assign resp_id = resp_id_r;
  assign session_identifier = id_r;
  assign tag_state = state_r;
  assign tag_selected = (state_r == tag_ac_pkg::ST_SELECTED);
endmodule

//--- tb/tag_ac_assertions.sv
// port checks for the tag anticollision state logic
`timescale 1ns/1ps
module tag_ac_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] probe_slot_number,
  input wire logic [7:0] cmd_select_id,
  input wire logic resp_valid,
  input wire logic [7:0] resp_id,
  input wire logic [7:0] session_identifier,
  input wire logic [2:0] tag_state,
  input wire logic tag_selected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  answer_cause_a: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  ready_quiet_a: assert property (cmd_valid && cmd_code inside {3'h1, 3'h2}
    && tag_state == 3'h0 |=> !resp_valid)
    else $error("ready tag answered");
  start_inv_a: assert property (cmd_valid && cmd_code == 3'h0 && tag_state
    == 3'h0 |=> resp_valid && tag_state == 3'h1
    && resp_id == session_identifier)
    else $error("start-inventory mishandled");
  poll_draw_a: assert property (cmd_valid && cmd_code == 3'h1 && tag_state
    == 3'h1 |=> resp_valid == (session_identifier[3:0] == 4'h0))
    else $error("poll answer wrong");
  poll_keep_a: assert property (cmd_valid && cmd_code == 3'h1 |=>
    session_identifier[7:4] == $past(session_identifier[7:4]))
    else $error("poll changed high nibble");
  probe_match_a: assert property (cmd_valid && cmd_code == 3'h2 && tag_state
    == 3'h1 && probe_slot_number != 4'h0 |=> resp_valid ==
    ($past(probe_slot_number) == session_identifier[3:0]))
    else $error("probe answer wrong");
  selected_quiet_a: assert property (cmd_valid && cmd_code <= 3'h2 &&
    tag_state == 3'h3 |=> !resp_valid && tag_state == 3'h3)
    else $error("selected tag answered");
  sel_flag_a: assert property (cmd_valid && cmd_code == 3'h3 &&
    cmd_select_id == session_identifier && tag_state inside {3'h1, 3'h2}
    |=> tag_selected && resp_valid && resp_id == $past(cmd_select_id))
    else $error("matching select not taken");
  deact_lock_a: assert property (tag_state == 3'h6 |=> tag_state == 3'h6
    && !resp_valid && !tag_selected)
    else $error("deactivated tag moved or answered");
endmodule

//--- tb/reader_model.sv
// reader side: sends one decoded command frame at a time
`timescale 1ns/1ps
module reader_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [3:0] probe_slot_number,
  output logic [7:0] cmd_select_id
);
  initial {cmd_valid, cmd_code, probe_slot_number, cmd_select_id} = '0;
  // idle fields show the inverse so stale values cannot be relied on
  task send(input logic [2:0] c, input logic [3:0] n, input logic [7:0] s);
    @(negedge sys_clk);
    {cmd_valid, cmd_code, probe_slot_number, cmd_select_id} = {1'b1, c, n, s};
    @(negedge sys_clk);
    {cmd_valid, cmd_code, probe_slot_number, cmd_select_id} = {1'b0, ~c, ~n, ~s};
  endtask
endmodule

//--- tb/tag_anticollision_sequence_tb.sv
// bench for the tag anticollision state logic
`timescale 1ns/1ps
module tag_anticollision_sequence_tb;
  logic sys_clk = 0, reset = 1, cmd_valid, resp_valid, tag_selected;
  logic [2:0] cmd_code, tag_state;
  logic [3:0] probe_slot_number;
  logic [7:0] cmd_select_id, resp_id, session_identifier;
  int bad_count = 0, num_checks = 0, seed = 38233, st = 0, r;
  logic [7:0] ids[$];
  reader_model rd(.*);
  tag_anticollision_sequence DUT(.*);
  initial forever #10 sys_clk = ~sys_clk;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // model: states use the design's codes, random draws read back
  task cmd(input int c, input int n, input logic [7:0] s);
    logic [7:0] old;
    logic ans;
    old = session_identifier;
    ans = 0;
    rd.send(c[2:0], n[3:0], s);
    case (c)
      0: if (st < 2) begin ans = 1; st = 1; end
      1: if (st == 1) ans = session_identifier[3:0] == 4'h0;
      2: if (st == 1 && n != 0) ans = n[3:0] == old[3:0];
      3: if (st inside {1, 2, 3}) begin
        if (s == old) begin ans = 1; st = 3; end
        else if (st == 3) st = 2;
      end
      4: if (st == 3) st = 6;
      5: if (st == 3) st = 1;
    endcase
    check(resp_valid, ans);
    if (ans) check(resp_id, session_identifier);
    if (c == 1) check(session_identifier[7:4], old[7:4]);
    if (c > 1) check(session_identifier, old);
    check(tag_state, st[2:0]);
    check(tag_selected, st == 3);
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 0;
    @(negedge sys_clk);
    cmd(1, 0, 0);
    cmd(2, 5, 0);
    cmd(0, 0, 0);
    cmd(1, 0, 0);
    if (resp_valid === 1'b1) ids.push_back(resp_id);
    for (int n = 1; n < 16; n++) begin
      cmd(2, n, 0);
      if (resp_valid === 1'b1) ids.push_back(resp_id);
    end
    cmd(2, 0, 0);
    check(ids.size(), 1);
    foreach (ids[i]) cmd(3, 0, ids[i]);
    for (int c = 0; c < 3; c++) cmd(c, session_identifier[3:0], 0);
    cmd(3, 0, ~session_identifier);
    cmd(3, 0, session_identifier);
    cmd(5, 0, 0);
    cmd(3, 0, session_identifier);
    cmd(4, 0, 0);
    cmd(0, 0, 0);
    reset = 1;
    st = 0;
    repeat (2) @(negedge sys_clk);
    reset = 0;
    @(negedge sys_clk);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      cmd(r[2:0] % 6, r[6:3], r[7] ? session_identifier : r[15:8]);
    end
    complete_run;
  end
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule
bind tag_anticollision_sequence tag_ac_assertions chk(.*);
